// File: src/dcr_pkg.sv
// Package for the DAC configuration register bank and start-up logic.
// Assumes a single core clock that stands for the DAC sample clock.
package dcr_pkg;
    // Register offsets (7-bit serial address space)
    localparam logic [6:0] DCR_ADDR_RESET   = 7'h01;
    localparam logic [6:0] DCR_ADDR_DCLKOUT = 7'h02;
    localparam logic [6:0] DCR_ADDR_DCLKIN  = 7'h03;
    localparam logic [6:0] DCR_ADDR_PORTS   = 7'h04;
    localparam logic [6:0] DCR_ADDR_GAIN    = 7'h09;
    localparam logic [6:0] DCR_ADDR_TMUX    = 7'h18;
    localparam logic [6:0] DCR_ADDR_TEMP    = 7'h19;
    localparam logic [6:0] DCR_ADDR_PGEN    = 7'h1E;
    localparam logic [6:0] DCR_ADDR_PVAL    = 7'h1F;
    // Field positions
    localparam int DCR_SWRST_BIT    = 0;
    localparam int DCR_CKOK_BIT     = 1;
    localparam int DCR_DCO_DIS_BIT  = 4;
    localparam int DCR_DCO_DIV_BIT  = 5;
    localparam int DCR_DCI_ON_BIT   = 0;
    localparam int DCR_DCI_Q_BIT    = 2;
    localparam int DCR_PA_ON_BIT    = 0;
    localparam int DCR_PB_ON_BIT    = 1;
    localparam int DCR_SP_BIT       = 2;
    localparam int DCR_DEN_BIT      = 3;
    localparam int DCR_TMUX_SEL_BIT = 0;
    localparam int DCR_TMUX_ADR_LSB = 1;
    localparam int DCR_TMUX_ON_BIT  = 6;
    localparam int DCR_TEMP_ON_BIT  = 0;
    localparam int DCR_TEMP_SEL_BIT = 1;
    localparam int DCR_PGEN_ON_BIT  = 0;
    localparam int DCR_GAIN_W       = 6;
    localparam int DCR_TMUX_ADR_W   = 5;
    // Reset values
    localparam logic [7:0]  DCR_RST_BYTE = 8'h00;
    localparam logic [15:0] DCR_MIDSCALE = 16'h8000;
    // Synchroniser start-up time
    localparam int DCR_CLK_PERIOD_NS = 20;
    localparam int DCR_SYNC_INIT_NS  = 1000000;
    localparam int DCR_SYNC_INIT_CYC =
        (DCR_SYNC_INIT_NS + DCR_CLK_PERIOD_NS - 1) / DCR_CLK_PERIOD_NS;
endpackage : dcr_pkg

// File: src/dcr_reg_if.sv
// Interface carrying decoded register accesses from the serial port.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
`default_nettype none
interface dcr_reg_if;
    logic       wr;     // One-cycle write strobe
    logic [6:0] addr;   // Register address
    logic [7:0] wdata;  // Write data
    logic [7:0] rdata;  // Read data for addr, registered
    modport port (output wr, output addr, output wdata, input rdata);
    modport bank (input wr, input addr, input wdata, output rdata);
endinterface : dcr_reg_if
`default_nettype wire

// File: src/dcr_spi_port.sv
// Serial register port: 16-bit frames, read flag, 7-bit address, 8 data bits.
// Assumes SCK far slower than the core clock; pins arrive asynchronous.
`timescale 1ns/10ps
`default_nettype none
module dcr_spi_port
    import dcr_pkg::*;
(
    input  wire logic i_clk,      // Core clock
    input  wire logic i_rst_n,    // Async reset, active low
    input  wire logic i_cs_n,     // Chip select pin, active low
    input  wire logic i_sck,      // Serial clock pin
    input  wire logic i_sdi,      // Serial data in pin
    output logic      o_sdo,      // Serial data out
    output logic      o_sdo_oe,   // High while driving SDO
    dcr_reg_if.port   rif         // Register access
);
    logic [2:0] cs_s, sck_s, sdi_s;  // [0] first stage, [1] second, [2] edge history
    logic [4:0] bit_cnt;
    logic [15:0] shin;
    logic [7:0] shout;
    logic       rd_frame;
    // Two-flop synchronisers; edge detect looks only at stage two and later
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cs_s  <= 3'h7;
            sck_s <= 3'h0;
            sdi_s <= 3'h0;
        end
        else
        begin
            cs_s  <= {cs_s[1:0], i_cs_n};
            sck_s <= {sck_s[1:0], i_sck};
            sdi_s <= {sdi_s[1:0], i_sdi};
        end
    end
    wire active = !cs_s[1];
    wire sck_rise = active && sck_s[1] && !sck_s[2];
    wire sck_fall = active && !sck_s[1] && sck_s[2];
    wire [15:0] next_shin = {shin[14:0], sdi_s[1]};
    // Shift in on rising SCK, shift out on falling; write on the 16th bit
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bit_cnt  <= 5'h00;
            shin     <= 16'h0000;
            shout    <= 8'h00;
            rd_frame <= 1'b0;
            rif.wr   <= 1'b0;
            rif.addr <= 7'h00;
            rif.wdata <= 8'h00;
            o_sdo    <= 1'b0;
            o_sdo_oe <= 1'b0;
        end
        else
        begin
            rif.wr   <= 1'b0;
            o_sdo_oe <= active;
            if (!active)
                bit_cnt <= 5'h00;
            else if (sck_rise)
            begin
                shin    <= next_shin;
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == 5'h07)
                begin
                    rd_frame <= next_shin[7];
                    rif.addr <= next_shin[6:0];
                end
                if (bit_cnt == 5'h0F && !rd_frame)
                begin
                    rif.wdata <= next_shin[7:0];
                    rif.wr    <= 1'b1;
                end
            end
            else if (sck_fall)
            begin
                // Read data already settled: address is stable since bit 8
                if (bit_cnt == 5'h08)
                begin
                    o_sdo <= rif.rdata[7];
                    shout <= {rif.rdata[6:0], 1'b0};
                end
                else
                begin
                    o_sdo <= shout[7];
                    shout <= {shout[6:0], 1'b0};
                end
            end
        end
    end
endmodule : dcr_spi_port
`default_nettype wire

// File: src/dcr_top.sv
// DAC configuration register bank with start-up synchroniser and data path.
// Assumes I_CORE_CLK stands for the sample clock; data pins are asynchronous.
// Functional notes
// - Six-bit gain trim, resets zero
// - Test mux select, address, enable fields
// - Temperature enable and select bits, reset zero
// - Pattern enable and eight-bit pattern value
// - Data clock out defaults to quarter rate
// - Synchroniser needs one millisecond before data
// - Port A precedes port B output
// - Port control bits; disabled data gives midscale
// - Data clock receiver enable and quadrature bit
`timescale 1ns/10ps
`default_nettype none
module dcr_top
    import dcr_pkg::*;
#(
    parameter int SYNC_INIT_CYCLES = DCR_SYNC_INIT_CYC  // Synchroniser start-up count
)(
    input  wire logic        I_CORE_CLK,          // Sample-rate core clock
    input  wire logic        I_RST_N,             // Async reset, active low
    input  wire logic        I_CS_N,              // Serial chip select
    input  wire logic        I_SCK,               // Serial clock
    input  wire logic        I_SDI,               // Serial data in
    input  wire logic [15:0] I_PORT_A_LANES,      // Port A data word
    input  wire logic [15:0] I_PORT_B_LANES,      // Port B data word
    output logic             O_SDO,               // Serial data out
    output logic             O_SDO_OE,            // SDO drive enable
    output logic             O_DATA_CLK_OUT,      // Divided data clock
    output logic [15:0]      O_DAC_CODE,          // Code to converter
    output logic             O_SYNC_READY,        // Synchroniser initialised
    output logic [5:0]       O_GAIN_TRIM,         // Gain trim field
    output logic             O_TEST_MUX_ON,       // Test mux enable
    output logic             O_TEMP_DIODE_ON,     // Temperature sense enable
    output logic             O_TEMP_SENSE_SELECT  // Diode or scaled voltage
);
    dcr_reg_if rif ();
    dcr_spi_port u_spi (
        .i_clk    (I_CORE_CLK),
        .i_rst_n  (I_RST_N),
        .i_cs_n   (I_CS_N),
        .i_sck    (I_SCK),
        .i_sdi    (I_SDI),
        .o_sdo    (O_SDO),
        .o_sdo_oe (O_SDO_OE),
        .rif      (rif)
    );

    logic [7:0]  dco_cfg, dci_cfg, port_cfg, gain, tmux, temp, pgen, pval;
    logic        soft_rst;
    logic [1:0]  div_cnt;
    logic [31:0] sync_cnt;
    logic [15:0] a_s1, a_s, b_s1, b_s, b_hold;
    logic        phase;

    // Write strobe decode, one wire per register
    function automatic logic hit(input logic [6:0] a);
        return rif.wr && rif.addr == a;
    endfunction : hit
    wire do_swrst = hit(DCR_ADDR_RESET) && rif.wdata[DCR_SWRST_BIT];
    wire w_dco  = hit(DCR_ADDR_DCLKOUT);
    wire w_dci  = hit(DCR_ADDR_DCLKIN);
    wire w_port = hit(DCR_ADDR_PORTS);
    wire w_gain = hit(DCR_ADDR_GAIN);
    wire w_tmux = hit(DCR_ADDR_TMUX);
    wire w_temp = hit(DCR_ADDR_TEMP);
    wire w_pgen = hit(DCR_ADDR_PGEN);
    wire w_pval = hit(DCR_ADDR_PVAL);
    // Writable masks keep reserved bits at zero
    wire [7:0] wd = rif.wdata;

    // Registers; soft reset clears every field a cycle after its write
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            soft_rst <= 1'b0;
            dco_cfg  <= DCR_RST_BYTE;
            dci_cfg  <= DCR_RST_BYTE;
            port_cfg <= DCR_RST_BYTE;
            gain     <= DCR_RST_BYTE;
            tmux     <= DCR_RST_BYTE;
            temp     <= DCR_RST_BYTE;
            pgen     <= DCR_RST_BYTE;
            pval     <= DCR_RST_BYTE;
        end
        else
        begin
            soft_rst <= do_swrst;
            if (soft_rst)
            begin
                dco_cfg  <= DCR_RST_BYTE;
                dci_cfg  <= DCR_RST_BYTE;
                port_cfg <= DCR_RST_BYTE;
                gain     <= DCR_RST_BYTE;
                tmux     <= DCR_RST_BYTE;
                temp     <= DCR_RST_BYTE;
                pgen     <= DCR_RST_BYTE;
                pval     <= DCR_RST_BYTE;
            end
            else
            begin
                if (w_dco)  dco_cfg  <= wd & 8'h30;
                if (w_dci)  dci_cfg  <= wd & 8'h05;
                if (w_port) port_cfg <= wd & 8'h0F;
                if (w_gain) gain     <= wd & 8'h3F;
                if (w_tmux) tmux     <= wd & 8'h7F;
                if (w_temp) temp     <= wd & 8'h03;
                if (w_pgen) pgen     <= wd & 8'h01;
                if (w_pval) pval     <= wd;
            end
        end
    end

    // Read mux; unmapped addresses read zero
    logic [7:0] next_rdata;
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (rif.addr)
            DCR_ADDR_DCLKOUT: next_rdata = dco_cfg | 8'h02;  // Clock present while running
            DCR_ADDR_DCLKIN:  next_rdata = dci_cfg;
            DCR_ADDR_PORTS:   next_rdata = port_cfg;
            DCR_ADDR_GAIN:    next_rdata = gain;
            DCR_ADDR_TMUX:    next_rdata = tmux;
            DCR_ADDR_TEMP:    next_rdata = temp;
            DCR_ADDR_PGEN:    next_rdata = pgen;
            DCR_ADDR_PVAL:    next_rdata = pval;
            default:          next_rdata = 8'h00;
        endcase
    end

    // Receivers are live once clock receiver and a port receiver are on; the
    // single-port select counts too, as the bring-up sets only that bit there
    wire rx_live = dci_cfg[DCR_DCI_ON_BIT] &&
                   (port_cfg[DCR_PA_ON_BIT] || port_cfg[DCR_PB_ON_BIT] ||
                    port_cfg[DCR_SP_BIT]);
    wire single  = port_cfg[DCR_SP_BIT];
    wire out_en  = port_cfg[DCR_DEN_BIT] && O_SYNC_READY;
    wire pg_on   = pgen[DCR_PGEN_ON_BIT];
    wire dco_fast = dco_cfg[DCR_DCO_DIV_BIT];
    wire dco_dis  = dco_cfg[DCR_DCO_DIS_BIT];

    // Code selection: midscale, pattern, single port, or A then B
    logic [15:0] next_code;
    always_comb
    begin
        if (!out_en)
            next_code = DCR_MIDSCALE;
        else if (pg_on)
            next_code = {pval, pval};
        else if (single)
            next_code = b_s;
        else
            next_code = phase ? b_hold : a_s;
    end

    // Data path, synchroniser counter and divided clock out
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rif.rdata      <= 8'h00;
            a_s1           <= 16'h0000;
            a_s            <= 16'h0000;
            b_s1           <= 16'h0000;
            b_s            <= 16'h0000;
            b_hold         <= 16'h0000;
            phase          <= 1'b0;
            O_DAC_CODE     <= DCR_MIDSCALE;
            div_cnt        <= 2'h0;
            O_DATA_CLK_OUT <= 1'b0;
            sync_cnt       <= 32'h0;
            O_SYNC_READY   <= 1'b0;
        end
        else
        begin
            rif.rdata <= next_rdata;
            a_s1   <= I_PORT_A_LANES;
            a_s    <= a_s1;
            b_s1   <= I_PORT_B_LANES;
            b_s    <= b_s1;
            phase  <= out_en ? !phase : 1'b0;
            if (!phase)
                b_hold <= b_s;
            O_DAC_CODE <= next_code;
            div_cnt    <= div_cnt + 2'h1;
            // Quarter rate by default, half rate when selected
            O_DATA_CLK_OUT <= !dco_dis && (dco_fast ? div_cnt[0] : div_cnt[1]);
            // Restart the wait when the clock receiver or every port receiver drops out
            if (!rx_live || soft_rst)
            begin
                sync_cnt     <= 32'h0;
                O_SYNC_READY <= 1'b0;
            end
            else if (sync_cnt < 32'(SYNC_INIT_CYCLES))
                sync_cnt <= sync_cnt + 32'h1;
            else
                O_SYNC_READY <= 1'b1;
        end
    end

    // Configuration outputs straight from register bits
    assign O_GAIN_TRIM         = gain[DCR_GAIN_W-1:0];
    assign O_TEST_MUX_ON       = tmux[DCR_TMUX_ON_BIT];
    assign O_TEMP_DIODE_ON     = temp[DCR_TEMP_ON_BIT];
    assign O_TEMP_SENSE_SELECT = temp[DCR_TEMP_SEL_BIT];

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);

    sequence s_dco_quarter;
        O_DATA_CLK_OUT [*2] ##1 !O_DATA_CLK_OUT [*2];
    endsequence
    wire dual_live = out_en && !pg_on && !single;

    chk_gain_write: assert property (w_gain && !soft_rst |=> gain == {2'b00, $past(wd[5:0])})
        else $error("gain trim write not stored");
    chk_tmux_write: assert property (w_tmux && !soft_rst |=> tmux == {1'b0, $past(wd[6:0])})
        else $error("test mux write not stored");
    chk_temp_write: assert property (w_temp && !soft_rst |=> temp == {6'h00, $past(wd[1:0])})
        else $error("temperature control write not stored");
    chk_pattern_out: assert property (out_en && pg_on |=> O_DAC_CODE == {$past(pval), $past(pval)})
        else $error("pattern value not driven");
    chk_dco_quarter: assert property ($rose(O_DATA_CLK_OUT) && !dco_fast && !dco_dis
                                      |-> s_dco_quarter ##1 O_DATA_CLK_OUT)
        else $error("data clock out not quarter rate");
    chk_sync_wait: assert property ($rose(O_SYNC_READY) |-> sync_cnt == 32'(SYNC_INIT_CYCLES) && $past(rx_live))
        else $error("synchroniser ready too early");
    chk_port_order: assert property (dual_live && !phase ##1 dual_live
                                     |-> O_DAC_CODE == $past(a_s) ##1 O_DAC_CODE == $past(b_s, 2))
        else $error("port B came before port A");
    chk_midscale: assert property (!out_en |=> O_DAC_CODE == DCR_MIDSCALE)
        else $error("disabled data not midscale");
    chk_dclk_write: assert property (w_dci && !soft_rst |=> dci_cfg == ($past(wd) & 8'h05))
        else $error("data clock register write not stored");
    chk_soft_reset: assert property (do_swrst |=> ##1 gain == 8'h00 && port_cfg == 8'h00 && pval == 8'h00)
        else $error("soft reset left a field set");
endmodule : dcr_top
`default_nettype wire

// File: dv/dcr_host_model.sv
// Host model: serial register master and data-port driver.
// Assumes pins are sampled on the core clock; SCK idles low.
`timescale 1ns/10ps
`default_nettype none
module dcr_host_model
    import dcr_pkg::*;
(
    input  wire logic        i_clk,    // Core clock
    input  wire logic        i_sdo,    // Device serial out
    output var  logic        o_cs_n,   // Chip select
    output var  logic        o_sck,    // Serial clock
    output var  logic        o_sdi,    // Serial data
    output var  logic [15:0] o_lane_a, // Port A word
    output var  logic [15:0] o_lane_b  // Port B word
);
    // Idle levels at time zero
    initial
    begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b0;
        o_lane_a = 16'h0000;
        o_lane_b = 16'h0000;
    end
    // One frame; five clocks per SCK phase keeps clear of the four-clock minimum
    task automatic spi(input logic rd, input logic [6:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        logic [15:0] f;
        f = {rd, a, d};
        q = 8'h00;
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        o_sdi <= f[15];
        for (int i = 15; i >= 0; i--)
        begin
            repeat (5) @(posedge i_clk);
            o_sck <= 1'b1;
            if (i < 8) q[i] = i_sdo;
            repeat (5) @(posedge i_clk);
            o_sck <= 1'b0;
            if (i > 0) o_sdi <= f[i-1];
        end
        repeat (5) @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_sdi <= ~f[0];  // Released line never keeps the last bit
        repeat (8) @(posedge i_clk);
    endtask : spi
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        spi(1'b0, a, d, q);
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [7:0] q);
        spi(1'b1, a, 8'h00, q);
    endtask : rd
    task automatic set_lanes(input logic [15:0] a, input logic [15:0] b);
        @(posedge i_clk);
        o_lane_a <= a;  // Core clock paces the words, standing in for the data clock
        o_lane_b <= b;
    endtask : set_lanes
    // Bring-up up to receiver enable; the data clock input has no pin here
    task automatic startup_pre(input logic single, input logic quad);
        wr(DCR_ADDR_RESET, 8'h01);
        o_lane_b <= 16'h0000;
        if (!single) o_lane_a <= 16'h0000;
        wr(DCR_ADDR_DCLKIN, quad ? 8'h05 : 8'h01);
        wr(DCR_ADDR_PORTS, single ? 8'h04 : 8'h06);
    endtask : startup_pre
    // Caller waits for the synchroniser first
    task automatic data_on(input logic single);
        wr(DCR_ADDR_PORTS, single ? 8'h0E : 8'h0B);
    endtask : data_on
endmodule : dcr_host_model
`default_nettype wire

// File: dv/dcr_top_bench.sv
// Bench for the DAC configuration bank: registers, start-up, data path.
// Assumes the host model drives every serial and data-port pin.
`timescale 1ns/10ps
`default_nettype none
module dcr_top_bench
    import dcr_pkg::*;
;
    localparam int SYNC = 40;      // Shortened synchroniser count
    localparam int LIMIT = 40000;  // About twice the expected run
    localparam logic [6:0] REGS [5] = '{DCR_ADDR_GAIN, DCR_ADDR_TMUX,
        DCR_ADDR_TEMP, DCR_ADDR_PGEN, DCR_ADDR_PVAL};
    localparam logic [6:0] RSVD [5] = '{7'h0A, 7'h17, 7'h1A, 7'h20, 7'h7F};
    logic clk, rst_n, cs_n, sck, sdi, sdo, sdo_oe, dclk, ready, tmux, temperature_sense_control, tsel;
    logic [15:0] la, lb, code;
    logic [5:0] gain;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 33;

    dcr_top #(.SYNC_INIT_CYCLES(SYNC)) dut_u (.I_CORE_CLK(clk), .I_RST_N(rst_n),
        .I_CS_N(cs_n), .I_SCK(sck), .I_SDI(sdi), .I_PORT_A_LANES(la),
        .I_PORT_B_LANES(lb), .O_SDO(sdo), .O_SDO_OE(sdo_oe), .O_DATA_CLK_OUT(dclk),
        .O_DAC_CODE(code), .O_SYNC_READY(ready), .O_GAIN_TRIM(gain),
        .O_TEST_MUX_ON(tmux), .O_TEMP_DIODE_ON(temperature_sense_control), .O_TEMP_SENSE_SELECT(tsel));
    dcr_host_model host_u (.i_clk(clk), .i_sdo(sdo), .o_cs_n(cs_n), .o_sck(sck),
        .o_sdi(sdi), .o_lane_a(la), .o_lane_b(lb));

    // Free-running core clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            fail_count++;
            end_sim();
        end
    end

    function automatic logic [7:0] exp_mask(input logic [6:0] a);
        case (a)
            DCR_ADDR_GAIN: return 8'h3F;
            DCR_ADDR_TMUX: return 8'h7F;
            DCR_ADDR_TEMP: return 8'h03;
            DCR_ADDR_PGEN: return 8'h01;
            DCR_ADDR_PVAL: return 8'hFF;
            default:       return 8'h00;
        endcase
    endfunction : exp_mask
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t reg got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_reg
    task automatic cmp_out(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t out got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_out
    task automatic end_sim();
        $display("Counts: compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // Cycles between two rising edges of the data clock output
    task automatic dclk_period(output int n);
        logic p;
        int t0;
        n = 0;
        t0 = -1;
        p = dclk;
        for (int k = 0; k < 40; k++)
        begin
            @(posedge clk);
            if (dclk === 1'b1 && p === 1'b0)
            begin
                if (t0 >= 0 && n == 0) n = k - t0;
                t0 = k;
            end
            p = dclk;
        end
    endtask : dclk_period
    task automatic wait_ready(output int n);
        n = 0;
        while (ready !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
    endtask : wait_ready

    // Main sequence
    initial
    begin : main
        logic [7:0] q, d;
        logic [7:0] sh [5];
        logic [15:0] a16, b16;
        int idx, n, first;
        rst_n = 1'b0;
        for (int i = 0; i < 5; i++) sh[i] = 8'h00;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        cmp_out(code, DCR_MIDSCALE);
        for (int i = 0; i < 5; i++)
        begin
            host_u.rd(REGS[i], q);
            cmp_reg(q, 8'h00);
        end
        // Serial output drive enable follows the frame
        fork
            host_u.rd(DCR_ADDR_GAIN, q);
            begin
                repeat (20) @(posedge clk);
                cmp_out({15'h0000, sdo_oe}, 16'h0001);
            end
        join
        cmp_out({15'h0000, sdo_oe}, 16'h0000);
        dclk_period(n);
        cmp_out(16'(n), 16'h0004);
        // Corners first (all ones, but temperature enable stays clear while the test mux is on), then random fields
        for (int i = 0; i < 30; i++)
        begin
            idx = (i < 5) ? i : int'($unsigned($random(seed)) % 5);
            d = (i < 5) ? 8'hFF : 8'($random(seed));
            if (idx == 1 && sh[2][0]) d[6] = 1'b0;
            if (idx == 2 && sh[1][6]) d[0] = 1'b0;
            sh[idx] = d & exp_mask(REGS[idx]);
            host_u.wr(REGS[idx], d);
            host_u.rd(REGS[idx], q);
            cmp_reg(q, sh[idx]);
            cmp_out({7'h00, gain, tmux, tsel, temperature_sense_control},
                    {7'h00, sh[0][5:0], sh[1][6], sh[2][1], sh[2][0]});
        end
        for (int i = 0; i < 5; i++)
        begin
            host_u.wr(RSVD[i], 8'hFF);
            host_u.rd(RSVD[i], q);
            cmp_reg(q, 8'h00);
        end
        host_u.wr(DCR_ADDR_RESET, 8'h01);
        for (int i = 0; i < 5; i++)
        begin
            host_u.rd(REGS[i], q);
            cmp_reg(q, 8'h00);
        end
        host_u.rd(DCR_ADDR_RESET, q);
        cmp_reg(q, 8'h00);
        dclk_period(n);
        cmp_out(16'(n), 16'h0004);
        // Dual-port bring-up, in phase
        host_u.startup_pre(1'b0, 1'b0);
        cmp_out({15'h0000, ready}, 16'h0000);
        wait_ready(n);
        cmp_out(16'(n >= SYNC - 15 && n <= SYNC + 5), 16'h0001);
        cmp_out(code, DCR_MIDSCALE);
        host_u.data_on(1'b0);
        host_u.rd(DCR_ADDR_PORTS, q);
        cmp_reg(q, 8'h0B);
        host_u.rd(DCR_ADDR_DCLKIN, q);
        cmp_reg(q, 8'h01);
        // A new pair must show its port A word first
        for (int r = 0; r < 3; r++)
        begin
            a16 = 16'($random(seed));
            b16 = a16 ^ 16'($random(seed) | 1);
            host_u.set_lanes(a16, b16);
            first = 0;
            for (int k = 0; k < 12; k++)
            begin
                @(posedge clk);
                if (first == 0 && code === a16) first = 1;
                if (first == 0 && code === b16) first = 2;
            end
            cmp_out(16'(first), 16'h0001);
        end
        d = 8'($random(seed));
        host_u.wr(DCR_ADDR_PVAL, d);
        host_u.wr(DCR_ADDR_PGEN, 8'h01);
        repeat (4) @(posedge clk);
        cmp_out(code, {d, d});
        host_u.wr(DCR_ADDR_PGEN, 8'h00);
        // Single-port bring-up, quadrature clock
        host_u.startup_pre(1'b1, 1'b1);
        wait_ready(n);
        cmp_out(16'(n >= SYNC - 15 && n <= SYNC + 5), 16'h0001);
        host_u.rd(DCR_ADDR_DCLKIN, q);
        cmp_reg(q, 8'h05);
        host_u.data_on(1'b1);
        b16 = 16'($random(seed));
        host_u.set_lanes(16'($random(seed)), b16);
        repeat (6) @(posedge clk);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            cmp_out(code, b16);
        end
        host_u.wr(DCR_ADDR_PORTS, 8'h06);
        repeat (4) @(posedge clk);
        cmp_out(code, DCR_MIDSCALE);
        host_u.wr(DCR_ADDR_RESET, 8'h01);
        cmp_out({15'h0000, ready}, 16'h0000);
        end_sim();
    end
endmodule : dcr_top_bench
`default_nettype wire
